//--- hdl/mmau_clkdiv.sv
// processor step generator: one step every 2**setting core clocks
// assumes the setting comes from configuration logic on the same clock
`timescale 1ns/1ps
module mmau_clkdiv
  import mmau_pkg::*;
#(
  parameter int W = DIV_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // setting and step
  input wire logic [W-1:0] div,
  output logic step
);
  typedef struct packed {
    logic [(1<<W)-2:0] cnt;
    logic step;
  } mmau_div_t;
  mmau_div_t q_reg, q_next;
  logic [(1<<W)-2:0] term;
  always_comb begin
    term = ((1 << W) - 1)'((1 << div) - 1);
    q_next = q_reg;
    // slower steps stretch every processor cycle alike
    if (q_reg.cnt >= term) begin
      q_next.cnt = '0;
      q_next.step = 1'b1;
    end else begin
      q_next.cnt = q_reg.cnt + 1'b1;
      q_next.step = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
  assign step = q_reg.step;
  AST_STEP_SPACING: assert property (@(posedge clk) disable iff (!arst_n)
    (step && div != '0) |=> !step) else $error("step too close");
endmodule

//--- hdl/mmau_core.sv
// memory access unit: program, internal and external data paths of the core
// assumes decoded ops from the core, same-clock memories, one op at a time
`timescale 1ns/1ps
module mmau_core
  import mmau_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // rate setting
  input wire logic [DIV_W-1:0] cpu_clock_divider,
  output logic cpu_step,
  // op request
  input wire logic op_valid,
  input wire mmau_op_t op_code,
  input wire logic [15:0] op_addr,
  input wire logic [7:0] op_wdata,
  output logic op_ready,
  // op answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // program memory
  output logic code_rd,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_rdata,
  // external data bus
  output logic mem_addr_en,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic processor_data_ram_sel,
  output logic ce_sel,
  output logic cfg_sel,
  input wire logic [7:0] mem_rdata
);
  typedef enum logic [2:0] {ST_IDLE, ST_RAM_WAIT, ST_RAM_USE, ST_XBUS, ST_CODE} mmau_st_t;
  typedef struct packed {
    mmau_st_t st;
    mmau_op_t op;
    logic [7:0] opd;
    logic [2:0] bitn;
    logic [15:0] pc;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [7:0] data_pointer_select;
    logic [7:0] memory_stretch_control;
    logic [7:0] program_status_word;
    logic [7:0] page;
    logic [3:0] cnt;
    logic [3:0] len;
    logic [3:0] wlen;
    logic mem_en;
    logic mem_rd;
    logic mem_wr;
    logic processor_data_ram_sel;
    logic ce_sel;
    logic cfg_sel;
    logic [15:0] mem_addr;
    logic code_rd;
    logic [15:0] code_addr;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_we;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } mmau_state_t;

  mmau_state_t q_reg, q_next;
  logic step;
  logic [7:0] ram_rdata;
  logic accept;
  logic [7:0] bbyte;
  logic [7:0] sbyte;

  mmau_clkdiv #(.W(DIV_W)) u_div (
    .clk(core_clk),
    .arst_n(arst_n),
    .div(cpu_clock_divider),
    .step(step)
  );

  mmau_iram #(.DEPTH(256), .AW(8)) u_iram (
    .clk(core_clk),
    .we(q_reg.ram_we),
    .addr(q_reg.ram_addr),
    .wdata(q_reg.ram_wdata),
    .rdata(ram_rdata)
  );

  function automatic logic is_xread(mmau_op_t o);
    return o == OP_XRD_RI || o == OP_XRD_DP;
  endfunction

  function automatic mmau_state_t finish(mmau_state_t s, logic [7:0] d);
    s.st = ST_IDLE;
    s.ready = 1'b1;
    s.rsp_valid = 1'b1;
    s.rsp_data = d;
    return s;
  endfunction

  // opens an external cycle; unmapped addresses raise no strobe
  function automatic mmau_state_t xstart(mmau_state_t s, logic [15:0] a);
    logic [3:0] str;
    logic [3:0] w;
    str = {1'b0, s.memory_stretch_control[STRETCH_W-1:0]};
    s.mem_addr = a;
    s.mem_en = 1'b1;
    s.processor_data_ram_sel = a <= PROCESSOR_DATA_RAM_HI;
    s.ce_sel = a >= CE_LO && a <= CE_HI;
    s.cfg_sel = a >= CFG_LO && a <= CFG_HI;
    w = s.ce_sel ? CE_WAIT : '0;
    s.mem_rd = is_xread(s.op) && (s.processor_data_ram_sel || s.ce_sel || s.cfg_sel);
    s.mem_wr = 1'b0;
    s.cnt = '0;
    s.len = is_xread(s.op) ? str + RD_EXTRA + w : str + WR_EXTRA + w;
    s.wlen = (str == '0) ? WR_MIN : str;
    s.st = ST_XBUS;
    return s;
  endfunction

  // direct upper half decodes to registers, others read undefined
  function automatic logic [7:0] sfr_rd(mmau_state_t s, logic [7:0] a);
    unique case (a)
      SFR_DPL: return s.dp0[7:0];
      SFR_DPH: return s.dp0[15:8];
      SFR_DPL1: return s.dp1[7:0];
      SFR_DPH1: return s.dp1[15:8];
      SFR_STRETCH: return s.memory_stretch_control;
      SFR_DPSEL: return s.data_pointer_select;
      SFR_PAGE: return s.page;
      SFR_PSW: return s.program_status_word;
      default: return UNDEF_BYTE;
    endcase
  endfunction

  function automatic mmau_state_t sfr_wr(mmau_state_t s, logic [7:0] a, logic [7:0] d);
    unique case (a)
      SFR_DPL: s.dp0[7:0] = d;
      SFR_DPH: s.dp0[15:8] = d;
      SFR_DPL1: s.dp1[7:0] = d;
      SFR_DPH1: s.dp1[15:8] = d;
      SFR_STRETCH: s.memory_stretch_control = d;
      SFR_DPSEL: s.data_pointer_select = {7'b0, d[DPS_BIT]};
      SFR_PAGE: s.page = d;
      SFR_PSW: s.program_status_word = d;
      default: s.memory_stretch_control = s.memory_stretch_control; // unimplemented writes vanish
    endcase
    return s;
  endfunction

  assign accept = step && op_valid && q_reg.ready;
  // bit space: low half maps onto 0x20..0x2f, high half onto x0/x8 registers
  assign bbyte = op_addr[7] ? {op_addr[7:3], 3'b000} : BIT_BASE + {4'b0000, op_addr[6:3]};
  assign sbyte = sfr_rd(q_reg, bbyte);

  always_comb begin
    q_next = q_reg;
    q_next.rsp_valid = 1'b0;
    q_next.ram_we = 1'b0;
    if (accept) begin
      q_next.op = op_code;
      q_next.opd = op_wdata;
      q_next.bitn = op_addr[2:0];
      q_next.ready = 1'b0;
      unique case (op_code)
        OP_FETCH: begin
          q_next.code_rd = 1'b1;
          q_next.code_addr = q_reg.pc;
          q_next.pc = q_reg.pc + 16'h0001;
          q_next.st = ST_CODE;
        end
        OP_CODE_MOVE: begin
          q_next.code_rd = 1'b1;
          q_next.code_addr = op_addr;
          q_next.st = ST_CODE;
        end
        OP_JUMP: begin
          q_next.pc = op_addr;
          q_next = finish(q_next, ZERO_BYTE);
        end
        OP_INT_ENTRY: begin
          q_next.pc = VEC_BASE + ({13'b0, op_addr[2:0]} << VEC_SHIFT);
          q_next = finish(q_next, ZERO_BYTE);
        end
        OP_DP_LOAD: begin
          if (q_reg.data_pointer_select[DPS_BIT]) begin
            q_next.dp1 = op_addr;
          end else begin
            q_next.dp0 = op_addr;
          end
          q_next = finish(q_next, ZERO_BYTE);
        end
        OP_DP_INC: begin
          if (q_reg.data_pointer_select[DPS_BIT]) begin
            q_next.dp1 = q_reg.dp1 + 16'h0001;
          end else begin
            q_next.dp0 = q_reg.dp0 + 16'h0001;
          end
          q_next = finish(q_next, ZERO_BYTE);
        end
        OP_XRD_DP, OP_XWR_DP: begin
          q_next = xstart(q_next, q_reg.data_pointer_select[DPS_BIT] ? q_reg.dp1 : q_reg.dp0);
        end
        OP_XRD_RI, OP_XWR_RI: begin
          // R0/R1 of the active bank, bank stride eight
          q_next.ram_addr = {3'b000, q_reg.program_status_word[PSW_RS_LSB +: 2], 2'b00, op_addr[0]};
          q_next.st = ST_RAM_WAIT;
        end
        OP_DIR_RD: begin
          if (op_addr[7:0] >= UPPER_BASE) begin
            q_next = finish(q_next, sfr_rd(q_reg, op_addr[7:0]));
          end else begin
            q_next.ram_addr = op_addr[7:0];
            q_next.st = ST_RAM_WAIT;
          end
        end
        OP_DIR_WR: begin
          if (op_addr[7:0] >= UPPER_BASE) begin
            q_next = sfr_wr(q_next, op_addr[7:0], op_wdata);
          end else begin
            q_next.ram_we = 1'b1;
            q_next.ram_addr = op_addr[7:0];
            q_next.ram_wdata = op_wdata;
          end
          q_next = finish(q_next, ZERO_BYTE);
        end
        OP_IND_RD: begin
          q_next.ram_addr = op_addr[7:0];
          q_next.st = ST_RAM_WAIT;
        end
        OP_IND_WR: begin
          q_next.ram_we = 1'b1;
          q_next.ram_addr = op_addr[7:0];
          q_next.ram_wdata = op_wdata;
          q_next = finish(q_next, ZERO_BYTE);
        end
        OP_BIT_RD: begin
          if (bbyte >= UPPER_BASE) begin
            q_next = finish(q_next, {7'b0, sbyte[op_addr[2:0]]});
          end else begin
            q_next.ram_addr = bbyte;
            q_next.st = ST_RAM_WAIT;
          end
        end
        OP_BIT_WR: begin
          if (bbyte >= UPPER_BASE) begin
            q_next = sfr_wr(q_next, bbyte, sbyte ^ ((sbyte[op_addr[2:0]] ^ op_wdata[0]) << op_addr[2:0]));
            q_next = finish(q_next, ZERO_BYTE);
          end else begin
            q_next.ram_addr = bbyte;
            q_next.st = ST_RAM_WAIT;
          end
        end
      endcase
    end else if (step) begin
      unique case (q_reg.st)
        ST_IDLE: q_next.ready = 1'b1;
        ST_RAM_WAIT: q_next.st = ST_RAM_USE;
        ST_RAM_USE: begin
          unique case (q_reg.op)
            OP_XRD_RI, OP_XWR_RI: q_next = xstart(q_next, {q_reg.page, ram_rdata});
            OP_BIT_RD: q_next = finish(q_next, {7'b0, ram_rdata[q_reg.bitn]});
            OP_BIT_WR: begin
              // read-modify-write keeps the other seven bits
              q_next.ram_we = 1'b1;
              q_next.ram_wdata = ram_rdata;
              q_next.ram_wdata[q_reg.bitn] = q_reg.opd[0];
              q_next = finish(q_next, ZERO_BYTE);
            end
            default: q_next = finish(q_next, ram_rdata);
          endcase
        end
        ST_XBUS: begin
          q_next.cnt = q_reg.cnt + 4'h1;
          q_next.mem_wr = !is_xread(q_reg.op) && (q_reg.processor_data_ram_sel || q_reg.ce_sel || q_reg.cfg_sel)
                          && (q_next.cnt <= q_reg.wlen);
          if (q_next.cnt == q_reg.len) begin
            q_next.mem_en = 1'b0;
            q_next.mem_rd = 1'b0;
            q_next.mem_wr = 1'b0;
            q_next.processor_data_ram_sel = 1'b0;
            q_next.ce_sel = 1'b0;
            q_next.cfg_sel = 1'b0;
            q_next = finish(q_next, (is_xread(q_reg.op) && q_reg.mem_rd) ? mem_rdata :
                            (is_xread(q_reg.op) ? UNDEF_BYTE : ZERO_BYTE));
          end
        end
        ST_CODE: begin
          q_next.code_rd = 1'b0;
          q_next = finish(q_next, code_rdata);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= '0;
      q_reg.st <= ST_IDLE;
      q_reg.pc <= PC_RESET;
      q_reg.memory_stretch_control <= MEMORY_STRETCH_CONTROL_RST;
      q_reg.ready <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign cpu_step = step;
  assign op_ready = q_reg.ready;
  assign rsp_valid = q_reg.rsp_valid;
  assign rsp_data = q_reg.rsp_data;
  assign code_rd = q_reg.code_rd;
  assign code_addr = q_reg.code_addr;
  assign mem_addr_en = q_reg.mem_en;
  assign mem_addr = q_reg.mem_addr;
  assign mem_rd = q_reg.mem_rd;
  assign mem_wr = q_reg.mem_wr;
  assign mem_wdata = q_reg.opd;
  assign processor_data_ram_sel = q_reg.processor_data_ram_sel;
  assign ce_sel = q_reg.ce_sel;
  assign cfg_sel = q_reg.cfg_sel;

  // helper counters: processor steps seen while each strobe stands
  logic [3:0] rd_steps, wr_steps, ad_steps;
  logic seen;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_steps <= '0;
      wr_steps <= '0;
      ad_steps <= '0;
      seen <= 1'b0;
    end else begin
      rd_steps <= mem_rd ? rd_steps + {3'b000, step} : '0;
      wr_steps <= mem_wr ? wr_steps + {3'b000, step} : '0;
      ad_steps <= mem_addr_en ? ad_steps + {3'b000, step} : '0;
      seen <= seen | accept;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_RESET_PC: assert property (!seen |-> q_reg.pc == PC_RESET) else $error("pc not at reset");
  AST_INT_VEC: assert property ((accept && op_code == OP_INT_ENTRY) |=>
    q_reg.pc == VEC_BASE + ({13'b0, $past(op_addr[2:0])} << VEC_SHIFT)) else $error("bad vector");
  AST_RD_LEN: assert property ($fell(mem_rd) |->
    rd_steps == {1'b0, q_reg.memory_stretch_control[2:0]} + RD_EXTRA + ($past(ce_sel) ? CE_WAIT : 4'h0))
    else $error("read strobe width");
  AST_WR_LEN: assert property ($fell(mem_wr) |->
    wr_steps == ((q_reg.memory_stretch_control[2:0] == 3'b000) ? WR_MIN : {1'b0, q_reg.memory_stretch_control[2:0]}))
    else $error("write strobe width");
  AST_WADDR_LEN: assert property (($fell(mem_addr_en) && !is_xread(q_reg.op)) |->
    ad_steps == {1'b0, q_reg.memory_stretch_control[2:0]} + WR_EXTRA + ($past(ce_sel) ? CE_WAIT : 4'h0))
    else $error("write address width");
  AST_MAPPED_ONLY: assert property ((mem_rd || mem_wr) |->
    (mem_addr <= PROCESSOR_DATA_RAM_HI || (mem_addr >= CE_LO && mem_addr <= CE_HI) || (mem_addr >= CFG_LO && mem_addr <= CFG_HI)))
    else $error("strobe on unmapped address");
  AST_RI_PAGE: assert property (($rose(mem_addr_en) && q_reg.op inside {OP_XRD_RI, OP_XWR_RI}) |->
    mem_addr[15:8] == q_reg.page) else $error("page byte wrong");
  AST_DP_SEL: assert property (($rose(mem_addr_en) && q_reg.op inside {OP_XRD_DP, OP_XWR_DP}) |->
    mem_addr == (q_reg.data_pointer_select[DPS_BIT] ? q_reg.dp1 : q_reg.dp0)) else $error("wrong pointer");
  AST_STRETCH_RST: assert property (!seen |-> q_reg.memory_stretch_control == MEMORY_STRETCH_CONTROL_RST) else $error("stretch reset");
  AST_RD_ONLY_READS: assert property (mem_rd |-> is_xread(q_reg.op)) else $error("read on write op");

  CV_READ: cover property ($fell(mem_rd));
  CV_WRITE: cover property ($fell(mem_wr));
  CV_CE_READ: cover property (mem_rd && ce_sel);
  CV_BIT_WR: cover property (accept && op_code == OP_BIT_WR);
endmodule

//--- hdl/mmau_iram.sv
// 256-byte internal data memory, registered read data
// assumes the owner holds address stable for one clock before using data
`timescale 1ns/1ps
module mmau_iram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // clock
  input wire logic clk,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  // contents need no reset, software initialises them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

//--- hdl/mmau_pkg.sv
// constants, opcodes and map of the processor memory access unit
// assumes one core clock and core-side requests already decoded into ops
package mmau_pkg;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam logic [15:0] PROCESSOR_DATA_RAM_LO = 16'h0000;
  localparam logic [15:0] PROCESSOR_DATA_RAM_HI = 16'h07ff;
  localparam logic [15:0] CE_LO = 16'h1000;
  localparam logic [15:0] CE_HI = 16'h11ff;
  localparam logic [15:0] CFG_LO = 16'h2000;
  localparam logic [15:0] CFG_HI = 16'h20ff;
  localparam logic [3:0] CE_WAIT = 4'h6;
  localparam logic [3:0] RD_EXTRA = 4'h1;
  localparam logic [3:0] WR_EXTRA = 4'h2;
  localparam logic [3:0] WR_MIN = 4'h1;
  localparam logic [7:0] UNDEF_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] MEMORY_STRETCH_CONTROL_RST = 8'h01;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_DPL1 = 8'h84;
  localparam logic [7:0] SFR_DPH1 = 8'h85;
  localparam logic [7:0] SFR_STRETCH = 8'h8e;
  localparam logic [7:0] SFR_DPSEL = 8'h92;
  localparam logic [7:0] SFR_PAGE = 8'hbf;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam int PSW_RS_LSB = 3;
  localparam int DPS_BIT = 0;
  localparam int STRETCH_W = 3;
  localparam int DIV_W = 3;
  typedef enum logic [3:0] {
    OP_FETCH, OP_JUMP, OP_INT_ENTRY, OP_CODE_MOVE,
    OP_XRD_RI, OP_XWR_RI, OP_XRD_DP, OP_XWR_DP,
    OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
    OP_BIT_RD, OP_BIT_WR, OP_DP_LOAD, OP_DP_INC
  } mmau_op_t;
endpackage

//--- tb/mmau_core_test.sv
// self-checking bench of the memory access unit with random and corner stimulus
// assumes mmau_mem_model on the far side and the unit's hand-over timing
`timescale 1ns/1ps
module mmau_core_test
  import mmau_pkg::*;
;
  logic core_clk, arst_n, op_valid, op_ready, rsp_valid, cpu_step, code_rd;
  logic mem_addr_en, mem_rd, mem_wr, processor_data_ram_sel, ce_sel, cfg_sel;
  logic [2:0] div;
  mmau_op_t op_code;
  logic [15:0] op_addr, code_addr, mem_addr;
  logic [7:0] op_wdata, rsp_data, code_rdata, mem_wdata, mem_rdata;
  logic [15:0] a_run, r_run, w_run, a_len, r_len, w_len, last_addr, code_seen, gap_cnt, gap_len;
  logic [2:0] last_sel;
  logic [31:0] seed = 32'h40;
  logic [15:0] a, x, wt;
  logic [15:0] holes [4] = '{16'h0800, 16'h1200, 16'h2100, 16'hffff};
  logic [7:0] d, r;
  int failures = 0;
  int total_checks = 0;
  int i, s;

  mmau_core uut (.core_clk(core_clk), .arst_n(arst_n), .cpu_clock_divider(div), .cpu_step(cpu_step),
    .op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_wdata(op_wdata), .op_ready(op_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .code_rd(code_rd), .code_addr(code_addr),
    .code_rdata(code_rdata), .mem_addr_en(mem_addr_en), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .processor_data_ram_sel(processor_data_ram_sel), .ce_sel(ce_sel), .cfg_sel(cfg_sel),
    .mem_rdata(mem_rdata));
  mmau_mem_model far (.core_clk(core_clk), .code_rd(code_rd), .code_addr(code_addr),
    .code_rdata(code_rdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .processor_data_ram_sel(processor_data_ram_sel), .ce_sel(ce_sel), .cfg_sel(cfg_sel),
    .mem_rdata(mem_rdata));

  always #12.5 core_clk = ~core_clk;

  // strobe widths are measured in core cycles, equal to steps while the divider is zero
  always @(posedge core_clk) begin
    if (mem_addr_en === 1'b1) begin
      a_run = a_run + 1;
      last_addr = mem_addr;
      last_sel = {processor_data_ram_sel, ce_sel, cfg_sel};
    end else if (a_run != 0) begin
      a_len = a_run;
      a_run = 0;
    end
    if (mem_rd === 1'b1) r_run = r_run + 1;
    else if (r_run != 0) begin
      r_len = r_run;
      r_run = 0;
    end
    if (mem_wr === 1'b1) w_run = w_run + 1;
    else if (w_run != 0) begin
      w_len = w_run;
      w_run = 0;
    end
    if (code_rd === 1'b1) code_seen = code_addr;
    if (cpu_step === 1'b1) begin
      gap_len = gap_cnt + 1;
      gap_cnt = 0;
    end else gap_cnt = gap_cnt + 1;
  end

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  function automatic logic [7:0] cb(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h3c;
  endfunction

  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the edge that takes it, answer awaited under a bound
  task automatic op(input mmau_op_t c, input logic [15:0] ad, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    logic tk;
    op_code = c;
    op_addr = ad;
    op_wdata = wd;
    op_valid = 1'b1;
    tk = 1'b0;
    for (n = 0; n < 300 && !tk; n++) begin
      tk = (cpu_step === 1'b1) && (op_ready === 1'b1);
      @(posedge core_clk);
      #1;
    end
    op_valid = 1'b0;
    for (n = 0; n < 300 && rsp_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    rd = rsp_data;
    if (n == 300 || !tk) begin
      failures++;
      give_verdict();
    end
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic ext(input mmau_op_t c, input logic [7:0] wd, output logic [7:0] rd);
    a_len = 0;
    r_len = 0;
    w_len = 0;
    last_sel = 3'h0;
    op(c, 16'h0001, wd, rd);
  endtask

  initial begin
    core_clk = 0; arst_n = 0; div = 0; op_valid = 0; op_code = OP_FETCH; op_addr = 0; op_wdata = 0;
    a_run = 0; r_run = 0; w_run = 0; gap_cnt = 0; gap_len = 0; code_seen = 16'hffff;
    repeat (16) @(posedge core_clk);
    #1;
    arst_n = 1;
    chk(op_ready, 1);
    op(OP_FETCH, 0, 0, r); chk(code_seen, PC_RESET);
    chk(r, cb(0));
    op(OP_DIR_RD, 16'h008e, 0, r); chk(r, 8'h01);
    op(OP_DIR_RD, 16'h0092, 0, r); chk(r, 8'h00);
    for (i = 0; i < 8; i++) begin
      op(OP_INT_ENTRY, 16'(i), 0, r);
      op(OP_FETCH, 0, 0, r); chk(code_seen, 16'h0003 + 16'(8 * i));
    end
    for (i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'hffff : rnd();
      op(OP_JUMP, a, 0, r);
      op(OP_FETCH, 0, 0, r); chk(code_seen, a); chk(r, cb(a));
      a = rnd();
      op(OP_CODE_MOVE, a, 0, r); chk(r, cb(a));
    end
    // every stretch value, rotating over the three populated regions
    for (s = 0; s < 8; s++) begin
      op(OP_DIR_WR, 16'h008e, 8'(s), r);
      op(OP_DIR_RD, 16'h008e, 0, r); chk(r, 16'(s));
      x = rnd();
      a = (s % 3 == 0) ? {5'h0, x[10:0]} : (s % 3 == 1) ? {7'h08, x[8:0]} : {8'h20, x[7:0]};
      wt = (s % 3 == 1) ? 16'd6 : 16'd0;
      op(OP_DIR_WR, 16'h0082, a[7:0], r);
      op(OP_DIR_WR, 16'h0083, a[15:8], r);
      d = x[15:8];
      ext(OP_XWR_DP, d, r); chk(last_addr, a);
      chk(last_sel, {s % 3 == 0, s % 3 == 1, s % 3 == 2});
      chk(a_len, 16'(s + 2) + wt); chk(w_len, (s == 0) ? 16'd1 : 16'(s));
      chk(r_len, 0);
      ext(OP_XRD_DP, 0, r); chk(r, d);
      chk(a_len, 16'(s + 1) + wt); chk(r_len, 16'(s + 1) + wt);
      chk(w_len, 0);
    end
    op(OP_DIR_WR, 16'h0092, 8'h01, r);
    op(OP_DIR_WR, 16'h0084, 8'h10, r);
    op(OP_DIR_WR, 16'h0085, 8'h20, r);
    ext(OP_XRD_DP, 0, r); chk(last_addr, 16'h2010);
    op(OP_DP_INC, 0, 0, r);
    ext(OP_XRD_DP, 0, r); chk(last_addr, 16'h2011);
    op(OP_DIR_WR, 16'h0092, 8'hfe, r);
    ext(OP_XRD_DP, 0, r); chk(last_addr, a);
    op(OP_DIR_RD, 16'h0084, 0, r); chk(r, 8'h11);
    // pointer load lands in the selected pointer only
    op(OP_DP_LOAD, 16'h1234, 0, r);
    op(OP_DIR_RD, 16'h0083, 0, r); chk(r, 8'h12);
    op(OP_DIR_RD, 16'h0085, 0, r); chk(r, 8'h20);
    // paged moves through R1 of each bank
    for (i = 0; i < 4; i++) begin
      x = rnd();
      op(OP_DIR_WR, 16'h00d0, {3'h0, 2'(i), 3'h0}, r);
      op(OP_DIR_WR, 16'(8 * i + 1), x[7:0], r);
      op(OP_DIR_WR, 16'h00bf, 8'h07, r);
      ext(OP_XWR_RI, x[15:8], r); chk(last_addr, {8'h07, x[7:0]});
      ext(OP_XRD_RI, 0, r); chk(r, x[15:8]);
    end
    for (i = 0; i < 4; i++) begin
      op(OP_DIR_WR, 16'h0082, holes[i][7:0], r);
      op(OP_DIR_WR, 16'h0083, holes[i][15:8], r);
      ext(OP_XRD_DP, 0, r); chk(r, 8'hff); chk(r_len, 0); chk(last_sel, 0);
      ext(OP_XWR_DP, 8'h3c, r); chk(w_len, 0);
    end
    x = rnd();
    op(OP_IND_WR, 16'h0090, x[7:0], r);
    op(OP_IND_RD, 16'h0090, 0, r); chk(r, x[7:0]);
    op(OP_DIR_RD, 16'h0091, 0, r); chk(r, 8'hff);
    op(OP_DIR_WR, 16'h0045, x[15:8], r);
    op(OP_IND_RD, 16'h0045, 0, r); chk(r, x[15:8]);
    op(OP_DIR_WR, 16'h002f, 8'h00, r);
    op(OP_BIT_WR, 16'h007f, 8'h01, r);
    op(OP_DIR_RD, 16'h002f, 0, r); chk(r, 8'h80);
    op(OP_DIR_WR, 16'h0020, 8'hff, r);
    op(OP_BIT_WR, 16'h0003, 8'h00, r);
    op(OP_BIT_RD, 16'h0003, 0, r); chk(r, 8'h00);
    op(OP_DIR_RD, 16'h0020, 0, r); chk(r, 8'hf7);
    // bit access to a register in the upper half, status word holds 0x18 here
    op(OP_BIT_RD, 16'h00d3, 0, r); chk(r, 8'h01);
    op(OP_BIT_WR, 16'h00d4, 8'h00, r);
    op(OP_DIR_RD, 16'h00d0, 0, r); chk(r, 8'h08);
    for (i = 1; i < 4; i++) begin
      div = 3'(i);
      repeat (40) @(posedge core_clk);
      #1;
      chk(gap_len, 16'(1 << i));
    end
    op(OP_DIR_RD, 16'h0092, 0, r); chk(r, 8'h00);
    div = 0;
    arst_n = 0;
    repeat (2) @(posedge core_clk);
    #1;
    arst_n = 1;
    op(OP_DIR_RD, 16'h008e, 0, r); chk(r, 8'h01);
    give_verdict();
  end
endmodule

//--- tb/mmau_mem_model.sv
// far-side model: program flash and the three external data memories
// assumes registered strobes and region selects from the unit on core_clk
`timescale 1ns/1ps
module mmau_mem_model (
  // clock
  input wire logic core_clk,
  // program memory
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_rdata,
  // external data bus
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic processor_data_ram_sel,
  input wire logic ce_sel,
  input wire logic cfg_sel,
  output logic [7:0] mem_rdata
);
  logic [7:0] processor_data_ram [2048];
  logic [7:0] ce_ram [512];
  logic [7:0] cfg_ram [256];
  logic [7:0] junk = 8'h5a;
  // a released bus shows a changing pattern so a stale byte never passes
  always @(posedge core_clk) begin
    junk <= ~junk;
    if (mem_wr && processor_data_ram_sel) processor_data_ram[mem_addr[10:0]] <= mem_wdata;
    if (mem_wr && ce_sel) ce_ram[mem_addr[8:0]] <= mem_wdata;
    if (mem_wr && cfg_sel) cfg_ram[mem_addr[7:0]] <= mem_wdata;
  end
  always_comb begin
    code_rdata = code_rd ? (code_addr[7:0] ^ code_addr[15:8] ^ 8'h3c) : junk;
    mem_rdata = junk;
    if (mem_rd && processor_data_ram_sel) mem_rdata = processor_data_ram[mem_addr[10:0]];
    if (mem_rd && ce_sel) mem_rdata = ce_ram[mem_addr[8:0]];
    if (mem_rd && cfg_sel) mem_rdata = cfg_ram[mem_addr[7:0]];
  end
endmodule
